// ### core/pspg_top.sv
// Two pulse trains locked to system time, with APB register access
// What this block does
// - Primary period is set in ns within its range, and zero disables it.
// - Primary output stays low while its period is zero.
// - Primary phase is below the primary period and resets to zero.
// - Secondary period is zero or in its range, zero disables, reset zero.
// - Secondary phase is below the secondary period and resets to zero.
// - One width in us, within bounds and below the smaller period, reset 4.
// - A readable flag is true only while the local clock is locked.
// - The signed 64-bit error to the master clock is readable.
// - The peak error is tracked and any write to it restarts tracking.
// - Current system time is readable as an unsigned 64-bit ns count.
// - Mean path delay to the master is readable as signed 64 bits.
// - Only the primary train drives sensor sync; the secondary does not.
//
// The placing of the registers and register access over APB were chosen for this implementation.
`timescale 1ns/1ps
module pspg_top (
	input  wire logic        CLOCK,
	input  wire logic        RST_N,
	input  wire logic        PSEL,
	input  wire logic        PENABLE,
	input  wire logic        PWRITE,
	input  wire logic [7:0]  PADDR,
	input  wire logic [31:0] PWDATA,
	output logic      [31:0] PRDATA,
	output logic             PREADY,
	output logic             PSLVERR,
	input  wire logic        LOCKED,
	input  wire logic [63:0] MASTER_ERR,
	input  wire logic [63:0] PATH_DELAY,
	input  wire logic        TIME_SET,
	input  wire logic [63:0] TIME_VALUE,
	output logic             SENSOR_SYNC,
	output logic             SEC_PULSE
);
	function automatic logic per_ok(input logic [31:0] v,
		input logic [31:0] lo, input logic [31:0] hi);
		per_ok = (v == 32'h0) || (v >= lo && v <= hi);
	endfunction

	function automatic logic width_ok(input logic [31:0] w,
		input logic [31:0] a, input logic [31:0] b);
		logic [63:0] ns;
		ns = 64'(w) * 64'(pspg_pkg::NS_PER_US);
		width_ok = w >= pspg_pkg::WIDTH_MIN && w <= pspg_pkg::WIDTH_MAX
			&& (a == 32'h0 || ns < 64'(a))
			&& (b == 32'h0 || ns < 64'(b));
	endfunction

	// Reset release through two flops
	logic rst_a_q;
	logic rst_n_s;
	always_ff @(posedge CLOCK or negedge RST_N) begin
		if (!RST_N) begin
			rst_a_q <= 1'b0;
			rst_n_s <= 1'b0;
		end else begin
			rst_a_q <= 1'b1;
			rst_n_s <= rst_a_q;
		end
	end

	// Register and status state
	pspg_pkg::pspg_train_t train_q [2];
	pspg_pkg::pspg_train_t train_d [2];
	logic [31:0] width_q, width_d;
	logic [63:0] time_q, time_d;
	logic [31:0] time_hi_q, time_hi_d;
	logic [63:0] err_q, peak_q, peak_d, delay_q;
	logic        locked_q;
	logic [31:0] prdata_q, prdata_d;
	logic        pready_q, pready_d, pslverr_q, pslverr_d;
	logic        restart [2];
	logic        setup, wr;
	logic [63:0] err_abs;

	assign setup   = PSEL && !PENABLE;
	assign wr      = PSEL && PENABLE && pready_q && PWRITE && !pslverr_q;
	assign err_abs = err_q[63] ? 64'(-err_q) : err_q;

	always_comb begin
		prdata_d  = 32'h0;
		pslverr_d = 1'b0;
		pready_d  = setup;
		time_hi_d = time_hi_q;
		train_d   = train_q;
		width_d   = width_q;
		restart[0] = TIME_SET;
		restart[1] = TIME_SET;
		// Time advances one clock period per cycle unless stepped
		time_d = TIME_SET ? TIME_VALUE : time_q + 64'(pspg_pkg::NS_PER_CYCLE);
		// Clear reloads the current sample so no event is lost
		peak_d = (err_abs > peak_q) ? err_abs : peak_q;
		if (setup) begin
			unique case (PADDR)
			pspg_pkg::OFS_PRI_PERIOD: begin
				prdata_d  = train_q[0].period;
				pslverr_d = PWRITE && !(per_ok(PWDATA,
					pspg_pkg::PRI_PER_MIN, pspg_pkg::PRI_PER_MAX)
					&& (PWDATA == 32'h0 || train_q[0].phase < PWDATA)
					&& width_ok(width_q, PWDATA, train_q[1].period));
			end
			pspg_pkg::OFS_PRI_PHASE: begin
				prdata_d  = train_q[0].phase;
				pslverr_d = PWRITE && PWDATA != 32'h0
					&& PWDATA >= train_q[0].period;
			end
			pspg_pkg::OFS_SEC_PERIOD: begin
				prdata_d  = train_q[1].period;
				pslverr_d = PWRITE && !(per_ok(PWDATA,
					pspg_pkg::SEC_PER_MIN, pspg_pkg::SEC_PER_MAX)
					&& (PWDATA == 32'h0 || train_q[1].phase < PWDATA)
					&& width_ok(width_q, train_q[0].period, PWDATA));
			end
			pspg_pkg::OFS_SEC_PHASE: begin
				prdata_d  = train_q[1].phase;
				pslverr_d = PWRITE && PWDATA != 32'h0
					&& PWDATA >= train_q[1].period;
			end
			pspg_pkg::OFS_WIDTH: begin
				prdata_d  = width_q;
				pslverr_d = PWRITE && !width_ok(PWDATA,
					train_q[0].period, train_q[1].period);
			end
			pspg_pkg::OFS_STATUS: begin
				prdata_d[pspg_pkg::LOCK_BIT] = locked_q;
				pslverr_d = PWRITE;
			end
			pspg_pkg::OFS_ERR_LO: begin
				prdata_d  = err_q[31:0];
				pslverr_d = PWRITE;
			end
			pspg_pkg::OFS_ERR_HI: begin
				prdata_d  = err_q[63:32];
				pslverr_d = PWRITE;
			end
			pspg_pkg::OFS_PEAK_LO: prdata_d = peak_q[31:0];
			pspg_pkg::OFS_PEAK_HI: prdata_d = peak_q[63:32];
			pspg_pkg::OFS_TIME_LO: begin
				// High half frozen so a lo-then-hi read is coherent
				prdata_d  = time_q[31:0];
				time_hi_d = time_q[63:32];
				pslverr_d = PWRITE;
			end
			pspg_pkg::OFS_TIME_HI: begin
				prdata_d  = time_hi_q;
				pslverr_d = PWRITE;
			end
			pspg_pkg::OFS_DELAY_LO: begin
				prdata_d  = delay_q[31:0];
				pslverr_d = PWRITE;
			end
			pspg_pkg::OFS_DELAY_HI: begin
				prdata_d  = delay_q[63:32];
				pslverr_d = PWRITE;
			end
			default: pslverr_d = 1'b1;
			endcase
		end
		if (wr) begin
			unique case (PADDR)
			pspg_pkg::OFS_PRI_PERIOD: train_d[0].period = PWDATA;
			pspg_pkg::OFS_PRI_PHASE:  train_d[0].phase  = PWDATA;
			pspg_pkg::OFS_SEC_PERIOD: train_d[1].period = PWDATA;
			pspg_pkg::OFS_SEC_PHASE:  train_d[1].phase  = PWDATA;
			pspg_pkg::OFS_WIDTH:      width_d = PWDATA;
			pspg_pkg::OFS_PEAK_LO,
			pspg_pkg::OFS_PEAK_HI:    peak_d = err_abs;
			default: ;
			endcase
			if (PADDR == pspg_pkg::OFS_PRI_PERIOD
				|| PADDR == pspg_pkg::OFS_PRI_PHASE)
				restart[0] = 1'b1;
			if (PADDR == pspg_pkg::OFS_SEC_PERIOD
				|| PADDR == pspg_pkg::OFS_SEC_PHASE)
				restart[1] = 1'b1;
		end
	end

	always_ff @(posedge CLOCK or negedge rst_n_s) begin
		if (!rst_n_s) begin
			for (int i = 0; i < 2; i++) begin
				train_q[i].period <= pspg_pkg::RST_PERIOD;
				train_q[i].phase  <= pspg_pkg::RST_PHASE;
			end
			width_q   <= pspg_pkg::RST_WIDTH;
			time_q    <= 64'h0;
			time_hi_q <= 32'h0;
			err_q     <= 64'h0;
			peak_q    <= 64'h0;
			delay_q   <= 64'h0;
			locked_q  <= 1'b0;
			prdata_q  <= 32'h0;
			pready_q  <= 1'b0;
			pslverr_q <= 1'b0;
		end else begin
			train_q   <= train_d;
			width_q   <= width_d;
			time_q    <= time_d;
			time_hi_q <= time_hi_d;
			err_q     <= MASTER_ERR;
			peak_q    <= peak_d;
			delay_q   <= PATH_DELAY;
			locked_q  <= LOCKED;
			prdata_q  <= prdata_d;
			pready_q  <= pready_d;
			pslverr_q <= pslverr_d;
		end
	end

	assign PRDATA  = prdata_q;
	assign PREADY  = pready_q;
	assign PSLVERR = pslverr_q;

	// Pulse trains: serial remainder aligns, then a phase counter runs
	pspg_pkg::pspg_state_t st_q [2];
	pspg_pkg::pspg_state_t st_d [2];
	logic [63:0] num_q [2];
	logic [63:0] num_d [2];
	logic [31:0] rem_q [2];
	logic [31:0] rem_d [2];
	logic [31:0] cnt_q [2];
	logic [31:0] cnt_d [2];
	logic [5:0]  step_q [2];
	logic [5:0]  step_d [2];
	logic [16:0] wcnt_q [2];
	logic [16:0] wcnt_d [2];
	logic        pulse_q [2];
	logic        pulse_d [2];
	logic        fire [2];
	logic [16:0] wlen;

	// Width up to 500 us fits 17 bits of cycles
	assign wlen = 17'(width_q[8:0] * pspg_pkg::CYC_PER_US);

	always_comb begin
		logic [32:0] rs;
		logic [31:0] c;
		rs = 33'h0;
		c  = 32'h0;
		for (int i = 0; i < 2; i++) begin
			st_d[i]   = st_q[i];
			num_d[i]  = num_q[i];
			rem_d[i]  = rem_q[i];
			cnt_d[i]  = cnt_q[i];
			step_d[i] = step_q[i];
			fire[i]   = 1'b0;
			unique case (st_q[i])
			pspg_pkg::PSPG_IDLE: begin
				// Adding one period keeps the dividend non-negative
				num_d[i]  = time_q + 64'(train_q[i].period)
					- 64'(train_q[i].phase);
				rem_d[i]  = 32'h0;
				step_d[i] = 6'h0;
				if (train_q[i].period != 32'h0)
					st_d[i] = pspg_pkg::PSPG_DIV;
			end
			pspg_pkg::PSPG_DIV: begin
				rs = {rem_q[i], num_q[i][63]};
				if (rs >= {1'b0, train_q[i].period})
					rs = rs - {1'b0, train_q[i].period};
				rem_d[i]  = rs[31:0];
				num_d[i]  = {num_q[i][62:0], 1'b0};
				step_d[i] = step_q[i] + 6'h1;
				if (step_q[i] == pspg_pkg::DIV_LAST) begin
					// Catch up the time spent dividing
					c = rs[31:0] + pspg_pkg::ALIGN_NS;
					if (c >= train_q[i].period)
						c = c - train_q[i].period;
					cnt_d[i] = c;
					fire[i]  = c < pspg_pkg::NS_PER_CYCLE;
					st_d[i]  = pspg_pkg::PSPG_RUN;
				end
			end
			pspg_pkg::PSPG_RUN: begin
				c = cnt_q[i] + pspg_pkg::NS_PER_CYCLE;
				if (c >= train_q[i].period)
					c = c - train_q[i].period;
				cnt_d[i] = c;
				fire[i]  = c < pspg_pkg::NS_PER_CYCLE;
			end
			default: st_d[i] = pspg_pkg::PSPG_IDLE;
			endcase
			if (restart[i] || train_q[i].period == 32'h0) begin
				st_d[i] = pspg_pkg::PSPG_IDLE;
				fire[i] = 1'b0;
			end
			if (train_q[i].period == 32'h0) begin
				wcnt_d[i]  = 17'h0;
				pulse_d[i] = 1'b0;
			end else if (fire[i]) begin
				wcnt_d[i]  = wlen - 17'h1;
				pulse_d[i] = 1'b1;
			end else if (wcnt_q[i] != 17'h0) begin
				wcnt_d[i]  = wcnt_q[i] - 17'h1;
				pulse_d[i] = 1'b1;
			end else begin
				wcnt_d[i]  = 17'h0;
				pulse_d[i] = 1'b0;
			end
		end
	end

	always_ff @(posedge CLOCK or negedge rst_n_s) begin
		if (!rst_n_s) begin
			for (int i = 0; i < 2; i++) begin
				st_q[i]    <= pspg_pkg::PSPG_IDLE;
				num_q[i]   <= 64'h0;
				rem_q[i]   <= 32'h0;
				cnt_q[i]   <= 32'h0;
				step_q[i]  <= 6'h0;
				wcnt_q[i]  <= 17'h0;
				pulse_q[i] <= 1'b0;
			end
		end else begin
			st_q    <= st_d;
			num_q   <= num_d;
			rem_q   <= rem_d;
			cnt_q   <= cnt_d;
			step_q  <= step_d;
			wcnt_q  <= wcnt_d;
			pulse_q <= pulse_d;
		end
	end

	// Measurement sync follows the primary train only
	assign SENSOR_SYNC = pulse_q[0];
	assign SEC_PULSE   = pulse_q[1];

	// Checks
	default clocking cb @(posedge CLOCK); endclocking
	default disable iff (!rst_n_s);

	a_pri_off_low: assert property (
		train_q[0].period == 32'h0 && $past(train_q[0].period) == 32'h0
		|-> !SENSOR_SYNC) else $error("primary pulse while disabled");
	a_pri_phase_ok: assert property (
		train_q[0].phase == 32'h0 || train_q[0].phase < train_q[0].period)
		else $error("primary phase not below period");
	a_sec_range_ok: assert property (
		train_q[1].period == 32'h0 || (train_q[1].period >=
		pspg_pkg::SEC_PER_MIN && train_q[1].period <= pspg_pkg::SEC_PER_MAX))
		else $error("secondary period out of range");
	a_width_fits: assert property (
		width_ok(width_q, train_q[0].period, train_q[1].period))
		else $error("pulse width out of range");
	a_lock_follows: assert property (
		##1 locked_q == $past(LOCKED))
		else $error("lock flag does not follow input");
	a_peak_holds: assert property (
		!(wr && (PADDR == pspg_pkg::OFS_PEAK_LO
		|| PADDR == pspg_pkg::OFS_PEAK_HI))
		|=> peak_q >= $past(peak_q) && peak_q >= $past(err_abs))
		else $error("peak error lost");
	a_time_step: assert property (
		!TIME_SET |=> time_q == $past(time_q) + 64'(pspg_pkg::NS_PER_CYCLE))
		else $error("system time did not advance");
	a_pulse_aligned: assert property (
		$rose(SENSOR_SYNC) && $stable(train_q[0])
		|-> (time_q + 64'(train_q[0].period) - 64'(train_q[0].phase))
		% 64'(train_q[0].period) < 64'(pspg_pkg::NS_PER_CYCLE))
		else $error("primary pulse not aligned");
	a_delay_mirror: assert property (
		##1 delay_q == $past(PATH_DELAY)) else $error("path delay stale");

	c_pri_pulse: cover property ($rose(SENSOR_SYNC));
	c_sec_pulse: cover property ($rose(SEC_PULSE));
	c_bad_write: cover property (PREADY && PSLVERR && PWRITE);
	c_peak_clear: cover property (wr && PADDR == pspg_pkg::OFS_PEAK_LO);
endmodule

// ### core/pspg_pkg.sv
// Constants and types for the synchronised pulse generator
package pspg_pkg;
	// Clock and time conversion
	localparam int          CLK_PERIOD_NS = 4;
	localparam logic [31:0] NS_PER_CYCLE  = 32'(CLK_PERIOD_NS);
	localparam logic [31:0] NS_PER_US     = 32'h0000_03E8;
	localparam logic [16:0] CYC_PER_US    = 17'(1000 / CLK_PERIOD_NS);
	// Alignment divider: one remainder bit per cycle
	localparam logic [5:0]  DIV_LAST      = 6'h3F;
	localparam logic [31:0] ALIGN_NS      = 32'((64 + 1) * CLK_PERIOD_NS);
	// Register byte offsets
	localparam logic [7:0] OFS_PRI_PERIOD = 8'h00;
	localparam logic [7:0] OFS_PRI_PHASE  = 8'h04;
	localparam logic [7:0] OFS_SEC_PERIOD = 8'h08;
	localparam logic [7:0] OFS_SEC_PHASE  = 8'h0C;
	localparam logic [7:0] OFS_WIDTH      = 8'h10;
	localparam logic [7:0] OFS_STATUS     = 8'h14;
	localparam logic [7:0] OFS_ERR_LO     = 8'h18;
	localparam logic [7:0] OFS_ERR_HI     = 8'h1C;
	localparam logic [7:0] OFS_PEAK_LO    = 8'h20;
	localparam logic [7:0] OFS_PEAK_HI    = 8'h24;
	localparam logic [7:0] OFS_TIME_LO    = 8'h28;
	localparam logic [7:0] OFS_TIME_HI    = 8'h2C;
	localparam logic [7:0] OFS_DELAY_LO   = 8'h30;
	localparam logic [7:0] OFS_DELAY_HI   = 8'h34;
	// Field position and legal ranges
	localparam int          LOCK_BIT      = 0;
	localparam logic [31:0] PRI_PER_MIN   = 32'h0001_86A0;
	localparam logic [31:0] PRI_PER_MAX   = 32'h003D_0900;
	localparam logic [31:0] SEC_PER_MIN   = 32'h0000_2710;
	localparam logic [31:0] SEC_PER_MAX   = 32'h3B9A_C9FF;
	localparam logic [31:0] WIDTH_MIN     = 32'h0000_0001;
	localparam logic [31:0] WIDTH_MAX     = 32'h0000_01F4;
	// Values after reset
	localparam logic [31:0] RST_PERIOD    = 32'h0000_0000;
	localparam logic [31:0] RST_PHASE     = 32'h0000_0000;
	localparam logic [31:0] RST_WIDTH     = 32'h0000_0004;

	typedef enum logic [1:0] {
		PSPG_IDLE = 2'b00,
		PSPG_DIV  = 2'b01,
		PSPG_RUN  = 2'b10
	} pspg_state_t;

	typedef struct packed {
		logic [31:0] period;
		logic [31:0] phase;
	} pspg_train_t;
endpackage

// ### tb/pspg_gm_model.sv
// Behavioural time master: lock, error, path delay and time steps
`timescale 1ns/1ps
module pspg_gm_model (
	input  wire logic        clk,
	output logic             locked,
	output logic [63:0]      master_err,
	output logic [63:0]      path_delay,
	output logic             time_set,
	output logic [63:0]      time_value
);
	// Servo values change only just after an edge
	task automatic servo(input logic lk, input logic [63:0] err,
		input logic [63:0] dly);
		@(posedge clk);
		locked <= lk;
		master_err <= err;
		path_delay <= dly;
	endtask
	// One-cycle step; stale value inverted so it is never reused
	task automatic step(input logic [63:0] t);
		@(posedge clk);
		time_set <= 1'b1;
		time_value <= t;
		@(posedge clk);
		time_set <= 1'b0;
		time_value <= ~t;
	endtask
	initial begin
		locked = 1'b0;
		master_err = 64'h0;
		path_delay = 64'h0;
		time_set = 1'b0;
		time_value = 64'h0;
	end
endmodule

// ### tb/ptp_sync_pulse_generator_test.sv
// Self-checking bench for the synchronised pulse generator
`timescale 1ns/1ps
module ptp_sync_pulse_generator_test;
	logic        clk, rst_n, psel, penable, pwrite, pready, pslverr;
	logic        locked, time_set, sensor_sync, sec_pulse;
	logic [7:0]  paddr;
	logic [31:0] pwdata, prdata, q;
	logic [63:0] master_err, path_delay, time_value;
	int          error_cnt, checks, cyc, n, hi, t0;
	logic        rose, sec_seen;

	pspg_top i_dut (.CLOCK(clk), .RST_N(rst_n), .PSEL(psel),
		.PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr),
		.PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
		.PSLVERR(pslverr), .LOCKED(locked), .MASTER_ERR(master_err),
		.PATH_DELAY(path_delay), .TIME_SET(time_set),
		.TIME_VALUE(time_value), .SENSOR_SYNC(sensor_sync),
		.SEC_PULSE(sec_pulse));
	pspg_gm_model i_gm (.clk(clk), .locked(locked),
		.master_err(master_err), .path_delay(path_delay),
		.time_set(time_set), .time_value(time_value));

	always #2 clk = ~clk;
	always @(posedge clk) cyc <= cyc + 1;

	task automatic wrap_up();
		$display("errors %0d checks %0d", error_cnt, checks);
		if (error_cnt == 0 && checks > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask
	task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp) begin
			error_cnt++;
			$display("wrong value at %0t: got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic chk_bit(input logic got, input logic exp);
		chk_word({31'h0, got}, {31'h0, exp});
	endtask
	// Master holds the request until pready is sampled high
	task automatic apb(input logic w, input logic [7:0] a,
		input logic [31:0] d, output logic [31:0] rq, output logic e);
		int k;
		@(posedge clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		k = 0;
		do begin
			@(posedge clk);
			k++;
		end while (pready !== 1'b1 && k < 50);
		if (pready !== 1'b1) begin
			error_cnt++;
			$display("wrong value at %0t: no ready", $time);
			wrap_up();
		end
		rq = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d,
		input logic experr);
		logic e;
		apb(1'b1, a, d, q, e);
		chk_bit(e, experr);
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] exp,
		input logic experr);
		logic e;
		apb(1'b0, a, 32'h0, q, e);
		chk_bit(e, experr);
		chk_word(q, exp);
	endtask
	// Cycles to next primary rise, with high time and secondary activity
	task automatic wait_rise(input int lim);
		logic last;
		n = 0;
		hi = 0;
		sec_seen = 1'b0;
		last = sensor_sync;
		do begin
			@(posedge clk);
			n++;
			hi += (last === 1'b1) ? 1 : 0;
			sec_seen |= (sec_pulse === 1'b1);
			rose = (sensor_sync === 1'b1) && (last === 1'b0);
			last = sensor_sync;
		end while (!rose && n < lim);
	endtask

	task automatic t_reset();
		chk_bit(sensor_sync, 1'b0);
		rd(pspg_pkg::OFS_PRI_PERIOD, pspg_pkg::RST_PERIOD, 1'b0);
		rd(pspg_pkg::OFS_PRI_PHASE, pspg_pkg::RST_PHASE, 1'b0);
		rd(pspg_pkg::OFS_SEC_PERIOD, pspg_pkg::RST_PERIOD, 1'b0);
		rd(pspg_pkg::OFS_SEC_PHASE, pspg_pkg::RST_PHASE, 1'b0);
		rd(pspg_pkg::OFS_WIDTH, pspg_pkg::RST_WIDTH, 1'b0);
		rd(pspg_pkg::OFS_PEAK_LO, 32'h0, 1'b0);
		rd(8'h38, 32'h0, 1'b1);
		wr(pspg_pkg::OFS_STATUS, 32'h1, 1'b1);
	endtask
	task automatic t_ranges();
		wr(pspg_pkg::OFS_PRI_PERIOD, pspg_pkg::PRI_PER_MIN - 1, 1'b1);
		wr(pspg_pkg::OFS_PRI_PERIOD, pspg_pkg::PRI_PER_MAX + 1, 1'b1);
		wr(pspg_pkg::OFS_PRI_PERIOD, pspg_pkg::PRI_PER_MAX, 1'b0);
		wr(pspg_pkg::OFS_PRI_PERIOD, pspg_pkg::PRI_PER_MIN, 1'b0);
		rd(pspg_pkg::OFS_PRI_PERIOD, pspg_pkg::PRI_PER_MIN, 1'b0);
		wr(pspg_pkg::OFS_PRI_PHASE, pspg_pkg::PRI_PER_MIN, 1'b1);
		wr(pspg_pkg::OFS_PRI_PHASE, 32'h0000_9C40, 1'b0);
		wr(pspg_pkg::OFS_SEC_PERIOD, pspg_pkg::SEC_PER_MIN - 1, 1'b1);
		wr(pspg_pkg::OFS_SEC_PERIOD, pspg_pkg::SEC_PER_MAX + 1, 1'b1);
		wr(pspg_pkg::OFS_SEC_PERIOD, pspg_pkg::SEC_PER_MIN, 1'b0);
		wr(pspg_pkg::OFS_SEC_PHASE, pspg_pkg::SEC_PER_MIN, 1'b1);
		wr(pspg_pkg::OFS_WIDTH, 32'h0, 1'b1);
		wr(pspg_pkg::OFS_WIDTH, pspg_pkg::WIDTH_MAX + 1, 1'b1);
		wr(pspg_pkg::OFS_WIDTH, 32'h0000_000A, 1'b1);
		wr(pspg_pkg::OFS_WIDTH, pspg_pkg::WIDTH_MIN, 1'b0);
		wr(pspg_pkg::OFS_SEC_PERIOD, 32'h0000_C350, 1'b0);
	endtask
	task automatic t_status();
		i_gm.servo(1'b1, 64'hFFFF_FFFF_FFFF_FFFB, 64'h0000_0000_0000_00C8);
		rd(pspg_pkg::OFS_STATUS, 32'h0000_0001, 1'b0);
		rd(pspg_pkg::OFS_ERR_LO, 32'hFFFF_FFFB, 1'b0);
		rd(pspg_pkg::OFS_ERR_HI, 32'hFFFF_FFFF, 1'b0);
		rd(pspg_pkg::OFS_DELAY_LO, 32'h0000_00C8, 1'b0);
		rd(pspg_pkg::OFS_DELAY_HI, 32'h0, 1'b0);
		i_gm.servo(1'b0, 64'h0000_0000_0000_0003, 64'h0);
		rd(pspg_pkg::OFS_STATUS, 32'h0, 1'b0);
		rd(pspg_pkg::OFS_PEAK_LO, 32'h0000_0005, 1'b0);
		wr(pspg_pkg::OFS_PEAK_LO, 32'h0, 1'b0);
		rd(pspg_pkg::OFS_PEAK_LO, 32'h0000_0003, 1'b0);
		i_gm.step(64'h0000_0001_0000_0000);
		// Low word first: it freezes the high word for the next read
		rd(pspg_pkg::OFS_TIME_LO, pspg_pkg::NS_PER_CYCLE, 1'b0);
		rd(pspg_pkg::OFS_TIME_HI, 32'h0000_0001, 1'b0);
	endtask
	// Phase, width and period of the primary train; secondary runs too
	task automatic t_pulse();
		i_gm.step(64'h0);
		t0 = cyc;
		wait_rise(26000);
		chk_bit(rose, 1'b1);
		chk_bit((((cyc - t0) * 4 + 16 - 40000) % 100000) < 32, 1'b1);
		wait_rise(26000);
		chk_word(n, 32'h0000_61A8);
		chk_word(hi, 32'h0000_00FA);
		chk_bit(sec_seen, 1'b1);
		wr(pspg_pkg::OFS_PRI_PHASE, 32'h0, 1'b0);
		wr(pspg_pkg::OFS_PRI_PERIOD, 32'h0, 1'b0);
		wait_rise(26000);
		chk_bit(rose, 1'b0);
	endtask

	initial begin
		clk = 1'b0;
		rst_n = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h0;
		pwdata = 32'h0;
		cyc = 0;
		error_cnt = 0;
		checks = 0;
		repeat (4) @(posedge clk);
		rst_n <= 1'b1;
		repeat (3) @(posedge clk);
		t_reset();
		t_ranges();
		t_status();
		t_pulse();
		wrap_up();
	end
endmodule
